/* hdl/uart_fifo.sv */
// Purpose: 128-character flip-flop FIFO used for both receive and transmit paths.
// Assumes: Head data is shown combinationally while not empty.
// Notes: Clear wins over push and pop in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "uart_params.svh"
module uart_fifo (
  input wire logic CLK,
  input wire logic RST,
  fifo_if.store f
);
  uart_pkg::fifo_state_type st_r;
  uart_pkg::fifo_state_type st_nxt;
  logic do_push;
  logic do_pop;

  assign do_push = f.push && (st_r.cnt != `UART_CNT_W'(`UART_FIFO_DEPTH));
  assign do_pop = f.pop && (st_r.cnt != 8'h00);
  assign f.rdata = st_r.mem[st_r.rd];
  assign f.count = st_r.cnt;
  assign f.full = (st_r.cnt == `UART_CNT_W'(`UART_FIFO_DEPTH));
  assign f.empty = (st_r.cnt == 8'h00);

  always_comb
  begin
    st_nxt = st_r;
    if (do_push)
    begin
      st_nxt.mem[st_r.wr] = f.wdata;
      st_nxt.wr = st_r.wr + 7'h01;
    end
    if (do_pop)
      st_nxt.rd = st_r.rd + 7'h01;
    st_nxt.cnt = st_r.cnt + {7'h00, do_push} - {7'h00, do_pop};
    if (f.clr)
    begin
      st_nxt.wr = 7'h00;
      st_nxt.rd = 7'h00;
      st_nxt.cnt = 8'h00;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule
`default_nettype wire

/* hdl/uart_top.sv */
// Purpose: Byte-wide serial port with deep FIFOs and RS-422, RS-485 and loopback line modes.
// Assumes: APB slave on the system clock; RXD is asynchronous and is synchronised here.
// Notes: Divisor is system clock cycles per bit and must be at least 2.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uart_params.svh"

// Overview of operation
// - Software sees byte-wide registers of a conventional serial port in the low data lane.
// - The receive and transmit FIFOs each physically hold 128 characters.
// - A programmable buffer depth sets how much of the FIFO the thresholds are based on.
// - Trigger settings decode to one character, a quarter, a half and depth minus two.
// - With a depth of sixteen the thresholds are 1, 4, 8 and 14 characters.
// - In RS-485 mode the line driver is off unless a character is being sent or the hold after its stop bit is running.
// - In RS-485 mode the driver stays on 800 ns after the last stop bit when nothing is left.
// - After reset the port is in RS-422 mode with driver and receiver always on.
// - In loopback mode the transmit bit stream feeds the receiver internally.
// - The buffer depth selects 16, 32, 64 or 128 characters, 16 after reset.
// - Parity may be none, odd or even, none after reset.
module uart_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RXD,
  output logic TXD,
  output logic DE,
  output logic RE_N,
  output logic IRQ
);
  uart_pkg::uart_state_type st_r;
  uart_pkg::uart_state_type st_nxt;
  fifo_if rxf();
  fifo_if txf();
  logic acc;
  logic [7:0] dep;
  logic [7:0] thr;
  logic ln;
  logic [4:0] ev;
  logic [4:0] w1c;
  logic [15:0] idle_cnt_r;

  uart_fifo rx_fifo (
    .CLK(CLK),
    .RST(RST),
    .f(rxf.store)
  );

  uart_fifo tx_fifo (
    .CLK(CLK),
    .RST(RST),
    .f(txf.store)
  );

  assign PRDATA = {24'h000000, st_r.prdata};
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign TXD = st_r.txd;
  assign DE = st_r.de;
  assign RE_N = st_r.re_n;
  assign IRQ = st_r.irq;

  always_comb
  begin
    st_nxt = st_r;
    ev = 5'h00;
    w1c = 5'h00;
    rxf.push = 1'b0;
    rxf.pop = 1'b0;
    rxf.clr = 1'b0;
    rxf.wdata = st_r.rx_sh;
    txf.push = 1'b0;
    txf.pop = 1'b0;
    txf.clr = 1'b0;
    txf.wdata = PWDATA[7:0];
    acc = PSEL && PENABLE && st_r.pready;
    st_nxt.sync = {st_r.sync[0], RXD};
    dep = `UART_BASE_DEPTH << st_r.depth;
    case (st_r.trig)
      2'h0: thr = 8'h01;
      2'h1: thr = dep >> 2;
      2'h2: thr = dep >> 1;
      default: thr = dep - 8'h02;
    endcase
    // The receiver is blind while this end drives a half-duplex line.
    if (st_r.mode == uart_pkg::MODE_LOOP)
      ln = st_r.txb;
    else if (st_r.mode == uart_pkg::MODE_RS485 && st_r.de)
      ln = 1'b1;
    else
      ln = st_r.sync[1];
    // Bus: one wait state, read data captured as the wait state ends.
    st_nxt.pready = PSEL && PENABLE && !st_r.pready;
    if (PSEL && PENABLE && !st_r.pready)
    begin
      st_nxt.pslverr = 1'b0;
      st_nxt.pop_pend = 1'b0;
      st_nxt.prdata = 8'h00;
      case (PADDR)
        `UART_OFF_DATA:
        begin
          st_nxt.prdata = rxf.empty ? 8'h00 : rxf.rdata;
          st_nxt.pop_pend = !PWRITE && !rxf.empty;
        end
        `UART_OFF_IMASK: st_nxt.prdata = {3'h0, st_r.mask};
        `UART_OFF_ISTAT: st_nxt.prdata = {3'h0, st_r.istat};
        `UART_OFF_FCTL: st_nxt.prdata = {6'h00, st_r.trig};
        `UART_OFF_LCTL: st_nxt.prdata = {2'h0, st_r.depth, st_r.mode, st_r.parity};
        `UART_OFF_LSTAT: st_nxt.prdata = {3'h0, txf.full, rxf.full,
          (st_r.tx_st == uart_pkg::TX_IDLE), txf.empty, !rxf.empty};
        `UART_OFF_DIVLO: st_nxt.prdata = st_r.div[7:0];
        `UART_OFF_DIVHI: st_nxt.prdata = st_r.div[15:8];
        `UART_OFF_RXLVL: st_nxt.prdata = rxf.count;
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    if (acc && !PWRITE && st_r.pop_pend)
      rxf.pop = 1'b1;
    if (acc && PWRITE && !st_r.pslverr)
    begin
      case (PADDR)
        `UART_OFF_DATA: txf.push = 1'b1;
        `UART_OFF_IMASK: st_nxt.mask = PWDATA[4:0];
        `UART_OFF_ISTAT: w1c = PWDATA[4:0];
        `UART_OFF_FCTL:
        begin
          st_nxt.trig = PWDATA[1:0];
          rxf.clr = PWDATA[`UART_FCTL_RXCLR];
          txf.clr = PWDATA[`UART_FCTL_TXCLR];
        end
        `UART_OFF_LCTL:
        begin
          st_nxt.parity = PWDATA[1:0];
          st_nxt.mode = PWDATA[3:2];
          st_nxt.depth = PWDATA[5:4];
        end
        `UART_OFF_DIVLO: st_nxt.div[7:0] = PWDATA[7:0];
        `UART_OFF_DIVHI: st_nxt.div[15:8] = PWDATA[7:0];
        default: st_nxt.div = st_r.div;
      endcase
    end

    // Transmitter.
    case (st_r.tx_st)
      uart_pkg::TX_IDLE:
      begin
        st_nxt.txb = 1'b1;
        if (!txf.empty)
        begin
          txf.pop = 1'b1;
          st_nxt.tx_sh = txf.rdata;
          st_nxt.tx_par = (st_r.parity == uart_pkg::PAR_ODD) ? ~^txf.rdata : ^txf.rdata;
          st_nxt.tx_st = uart_pkg::TX_START;
          st_nxt.tx_cnt = st_r.div - 16'h0001;
          st_nxt.txb = 1'b0;
          st_nxt.hold = 8'h00;
        end
        else if (st_r.hold != 8'h00)
          st_nxt.hold = st_r.hold - 8'h01;
      end
      uart_pkg::TX_START, uart_pkg::TX_DATA, uart_pkg::TX_PAR, uart_pkg::TX_STOP:
      begin
        if (st_r.tx_cnt != 16'h0000)
          st_nxt.tx_cnt = st_r.tx_cnt - 16'h0001;
        else
        begin
          st_nxt.tx_cnt = st_r.div - 16'h0001;
          case (st_r.tx_st)
            uart_pkg::TX_START:
            begin
              st_nxt.tx_st = uart_pkg::TX_DATA;
              st_nxt.tx_bit = 3'h0;
              st_nxt.txb = st_r.tx_sh[0];
            end
            uart_pkg::TX_DATA:
            begin
              if (st_r.tx_bit == 3'h7)
              begin
                st_nxt.tx_st = (st_r.parity == uart_pkg::PAR_NONE) ?
                  uart_pkg::TX_STOP : uart_pkg::TX_PAR;
                st_nxt.txb = (st_r.parity == uart_pkg::PAR_NONE) ? 1'b1 : st_r.tx_par;
              end
              else
              begin
                st_nxt.tx_bit = st_r.tx_bit + 3'h1;
                st_nxt.tx_sh = {1'b0, st_r.tx_sh[7:1]};
                st_nxt.txb = st_r.tx_sh[1];
              end
            end
            uart_pkg::TX_PAR:
            begin
              st_nxt.tx_st = uart_pkg::TX_STOP;
              st_nxt.txb = 1'b1;
            end
            default:
            begin
              st_nxt.tx_st = uart_pkg::TX_IDLE;
              st_nxt.hold = 8'(`UART_DE_HOLD_CYC);
              ev[`UART_EV_TXDONE] = txf.empty;
            end
          endcase
        end
      end
      default: st_nxt.tx_st = uart_pkg::TX_IDLE;
    endcase

    // Line drivers follow the mode; loopback keeps the outside line quiet.
    case (st_r.mode)
      uart_pkg::MODE_RS485:
      begin
        st_nxt.de = (st_nxt.tx_st != uart_pkg::TX_IDLE) || (st_nxt.hold != 8'h00);
        st_nxt.re_n = st_nxt.de;
        st_nxt.txd = st_nxt.txb;
      end
      uart_pkg::MODE_LOOP:
      begin
        st_nxt.de = 1'b0;
        st_nxt.re_n = 1'b1;
        st_nxt.txd = 1'b1;
      end
      default:
      begin
        st_nxt.de = 1'b1;
        st_nxt.re_n = 1'b0;
        st_nxt.txd = st_nxt.txb;
      end
    endcase

    // Receiver samples each bit at its middle.
    case (st_r.rx_st)
      uart_pkg::RX_IDLE:
        if (!ln)
        begin
          st_nxt.rx_st = uart_pkg::RX_START;
          st_nxt.rx_cnt = st_r.div >> 1;
        end
      uart_pkg::RX_START, uart_pkg::RX_DATA, uart_pkg::RX_PAR, uart_pkg::RX_STOP:
      begin
        if (st_r.rx_cnt != 16'h0000)
          st_nxt.rx_cnt = st_r.rx_cnt - 16'h0001;
        else
        begin
          st_nxt.rx_cnt = st_r.div - 16'h0001;
          case (st_r.rx_st)
            uart_pkg::RX_START:
            begin
              st_nxt.rx_st = ln ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
              st_nxt.rx_bit = 3'h0;
            end
            uart_pkg::RX_DATA:
            begin
              st_nxt.rx_sh = {ln, st_r.rx_sh[7:1]};
              st_nxt.rx_bit = st_r.rx_bit + 3'h1;
              if (st_r.rx_bit == 3'h7)
                st_nxt.rx_st = (st_r.parity == uart_pkg::PAR_NONE) ?
                  uart_pkg::RX_STOP : uart_pkg::RX_PAR;
            end
            uart_pkg::RX_PAR:
            begin
              st_nxt.rx_par = ln;
              st_nxt.rx_st = uart_pkg::RX_STOP;
            end
            default:
            begin
              // Characters with parity or framing errors are still stored; the flags tell software.
              rxf.push = 1'b1;
              st_nxt.rx_st = uart_pkg::RX_IDLE;
              ev[`UART_EV_FRAME] = !ln;
              ev[`UART_EV_OVERRUN] = rxf.full;
              ev[`UART_EV_PARITY] = (st_r.parity == uart_pkg::PAR_ODD) ?
                (st_r.rx_par != ~^st_r.rx_sh) :
                ((st_r.parity == uart_pkg::PAR_EVEN) && (st_r.rx_par != ^st_r.rx_sh));
            end
          endcase
        end
      end
      default: st_nxt.rx_st = uart_pkg::RX_IDLE;
    endcase

    ev[`UART_EV_RXTRIG] = (rxf.count >= thr);
    st_nxt.istat = (st_r.istat & ~w1c) | ev;
    st_nxt.irq = |(st_r.istat & st_r.mask);
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_r <= '0;
      st_r.sync <= 2'h3;
      st_r.trig <= `UART_TRIG_RST;
      st_r.depth <= `UART_DEPTH_RST;
      st_r.parity <= `UART_PAR_RST;
      st_r.mode <= `UART_MODE_RST;
      st_r.div <= `UART_DIV_RST;
      st_r.tx_st <= uart_pkg::TX_IDLE;
      st_r.rx_st <= uart_pkg::RX_IDLE;
      st_r.txb <= 1'b1;
      st_r.txd <= 1'b1;
      st_r.de <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Helper for checking the driver release: cycles since the transmitter went idle.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      idle_cnt_r <= 16'h0000;
    else if (st_r.tx_st != uart_pkg::TX_IDLE)
      idle_cnt_r <= 16'h0000;
    else if (idle_cnt_r != 16'hFFFF)
      idle_cnt_r <= idle_cnt_r + 16'h0001;
  end

  rs422_drive_a: assert property (@(posedge CLK) disable iff (RST)
    st_r.mode == uart_pkg::MODE_RS422 |=> DE && !RE_N)
    else $error("RS-422 mode did not keep driver and receiver enabled");

  rs485_busy_de_a: assert property (@(posedge CLK) disable iff (RST)
    st_r.mode == uart_pkg::MODE_RS485 && $stable(st_r.mode) &&
    st_r.tx_st != uart_pkg::TX_IDLE |=> DE)
    else $error("Driver not enabled during RS-485 transmission");

  de_release_a: assert property (@(posedge CLK) disable iff (RST)
    $fell(DE) && st_r.mode == uart_pkg::MODE_RS485 && $past(st_r.mode) == uart_pkg::MODE_RS485
    |-> idle_cnt_r >= 16'(`UART_DE_HOLD_CYC))
    else $error("RS-485 driver released before the hold time");

  de_hold_a: assert property (@(posedge CLK) disable iff (RST)
    st_r.mode == uart_pkg::MODE_RS485 && st_r.tx_st == uart_pkg::TX_STOP &&
    st_nxt.tx_st == uart_pkg::TX_IDLE && $stable(st_r.mode) |=> DE [*8])
    else $error("RS-485 driver dropped right after the stop bit");

  loop_quiet_a: assert property (@(posedge CLK) disable iff (RST)
    st_r.mode == uart_pkg::MODE_LOOP && $stable(st_r.mode) && st_r.tx_st == uart_pkg::TX_START
    |-> !ln && TXD)
    else $error("Loopback start bit did not reach the receiver");

  thr_classic_a: assert property (@(posedge CLK) disable iff (RST)
    st_r.depth == 2'h0 |-> (st_r.trig == 2'h1 && thr == 8'h04) || (st_r.trig == 2'h2 &&
    thr == 8'h08) || (st_r.trig == 2'h3 && thr == 8'h0E) || (st_r.trig == 2'h0 && thr == 8'h01))
    else $error("Depth 16 thresholds differ from 1, 4, 8, 14");

  thr_deep_a: assert property (@(posedge CLK) disable iff (RST)
    st_r.depth == 2'h3 && st_r.trig == 2'h3 |-> thr == 8'h7E)
    else $error("Depth 128 top threshold is not 126");

  fifo_cap_a: assert property (@(posedge CLK) disable iff (RST)
    txf.count <= 8'h80 && rxf.count <= 8'h80 && (txf.full == (txf.count == 8'h80)))
    else $error("FIFO count beyond 128 characters");

  start_bit_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(st_r.tx_st == uart_pkg::TX_START) && st_r.mode != uart_pkg::MODE_LOOP &&
    $stable(st_r.mode) |-> !TXD)
    else $error("Start bit not driven low");

  rx_trig_a: assert property (@(posedge CLK) disable iff (RST)
    rxf.count >= thr && st_r.mask[`UART_EV_RXTRIG] ##1 st_r.mask[`UART_EV_RXTRIG] |=> IRQ)
    else $error("Receive threshold did not raise the interrupt");
endmodule
`default_nettype wire

/* inc/fifo_if.sv */
// Purpose: Carrier between the serial port core and one of its character FIFOs.
// Assumes: All signals belong to the system clock domain.
// Notes: Push into a full FIFO and pop from an empty one are ignored.
`timescale 1ns/1ps
`default_nettype none
interface fifo_if;
  logic push;
  logic pop;
  logic clr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] count;
  logic full;
  logic empty;
  modport owner(output push, output pop, output clr, output wdata,
    input rdata, input count, input full, input empty);
  modport store(input push, input pop, input clr, input wdata,
    output rdata, output count, output full, output empty);
endinterface
`default_nettype wire

/* inc/uart_params.svh */
// Purpose: Register offsets, field positions, reset values and timing counts of the serial port.
// Assumes: 100 MHz system clock; APB data register bytes sit in the low lane.
// Notes: Definitions only.
`ifndef UART_PARAMS_SVH
`define UART_PARAMS_SVH

`define UART_CLK_MHZ 100
`define UART_FIFO_DEPTH 128
`define UART_PTR_W 7
`define UART_CNT_W 8

`define UART_OFF_DATA 8'h00
`define UART_OFF_IMASK 8'h04
`define UART_OFF_ISTAT 8'h08
`define UART_OFF_FCTL 8'h0C
`define UART_OFF_LCTL 8'h10
`define UART_OFF_LSTAT 8'h14
`define UART_OFF_DIVLO 8'h18
`define UART_OFF_DIVHI 8'h1C
`define UART_OFF_RXLVL 8'h20

`define UART_EV_RXTRIG 0
`define UART_EV_TXDONE 1
`define UART_EV_PARITY 2
`define UART_EV_FRAME 3
`define UART_EV_OVERRUN 4

`define UART_FCTL_RXCLR 2
`define UART_FCTL_TXCLR 3

`define UART_TRIG_RST 2'h3
`define UART_DEPTH_RST 2'h0
`define UART_PAR_RST 2'h0
`define UART_MODE_RST 2'h0
`define UART_DIV_RST 16'h0364
`define UART_BASE_DEPTH 8'h10

`define UART_DE_HOLD_NS 800
`define UART_DE_HOLD_CYC ((`UART_DE_HOLD_NS * `UART_CLK_MHZ + 999) / 1000)

`endif

/* inc/uart_pkg.sv */
// Purpose: Types shared by the serial port modules.
// Assumes: Constants come from uart_params.svh.
// Notes: State machines use one-hot codes.
package uart_pkg;
  typedef enum logic [1:0] {MODE_RS422 = 2'h0, MODE_RS485 = 2'h1, MODE_LOOP = 2'h2} mode_type;
  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2} parity_type;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
  } tx_state_type;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } rx_state_type;

  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [6:0] wr;
    logic [6:0] rd;
    logic [7:0] cnt;
  } fifo_state_type;

  typedef struct packed {
    logic [1:0] sync;
    logic pready;
    logic [7:0] prdata;
    logic pslverr;
    logic pop_pend;
    logic [4:0] mask;
    logic [4:0] istat;
    logic irq;
    logic [1:0] trig;
    logic [1:0] depth;
    logic [1:0] parity;
    logic [1:0] mode;
    logic [15:0] div;
    tx_state_type tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic txb;
    logic txd;
    logic de;
    logic re_n;
    logic [7:0] hold;
    rx_state_type rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
  } uart_state_type;
endpackage

/* verification/deep_fifo_uart_line_modes_tb.sv */
// Purpose: Self-checking bench of the serial port through APB and the line.
// Assumes: Divisor is set to 4 cycles per bit before any traffic.
// Notes: Thresholds are reached in loopback so that both FIFOs see deep fills.
`timescale 1ns/1ps
`default_nettype none
`include "uart_params.svh"
module deep_fifo_uart_line_modes_tb;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, RXD, TXD, DE, RE_N, IRQ;
  logic [31:0] q;
  logic serr;
  int num_errors = 0;
  int total_checks = 0;
  uart_top i_uart_top (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD), .DE(DE), .RE_N(RE_N), .IRQ(IRQ));
  uart_line_node i_uart_line_node (.clk(CLK), .txd(TXD), .rxd(RXD));
  always #5 CLK = ~CLK;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    q = PRDATA;
    serr = PSLVERR;
    if (n >= 20)
    begin
      check("pready", 0, 1);
      test_done();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_lvl(input int n);
    int k;
    k = 0;
    do
    begin
      rd(`UART_OFF_RXLVL);
      k++;
    end
    while (q !== 32'(n) && k < 3000);
    check("rx level", q, 32'(n));
    if (q !== 32'(n))
      test_done();
  endtask
  task automatic tx_expect(input logic [7:0] b);
    int n;
    n = 0;
    while (i_uart_line_node.got_q.size() == 0 && n < 500)
    begin
      @(posedge CLK);
      n++;
    end
    check("frame count", 32'(i_uart_line_node.got_q.size()), 1);
    if (i_uart_line_node.got_q.size() > 0)
      check("line byte", {24'h0, i_uart_line_node.got_q.pop_front()}, {24'h0, b});
    else
      test_done();
    check("line errors", 32'(i_uart_line_node.perr), 0);
  endtask
  task automatic t_regs;
    logic [7:0] offs [9];
    logic [31:0] exps [9];
    offs = '{`UART_OFF_LCTL, `UART_OFF_FCTL, `UART_OFF_DIVLO, `UART_OFF_DIVHI,
      `UART_OFF_LSTAT, `UART_OFF_RXLVL, `UART_OFF_IMASK, `UART_OFF_ISTAT, `UART_OFF_DATA};
    exps = '{32'h0, 32'h3, 32'h64, 32'h3, 32'h6, 32'h0, 32'h0, 32'h0, 32'h0};
    check("DE", DE, 1);
    check("RE_N", RE_N, 0);
    check("TXD", TXD, 1);
    for (int i = 0; i < 9; i++)
    begin
      rd(offs[i]);
      check("reset value", q, exps[i]);
    end
    rd(8'h24);
    check("slverr", serr, 1);
    check("unmapped data", q, 0);
    for (int d = 0; d < 4; d++)
    begin
      wr(`UART_OFF_LCTL, 32'(d << 4));
      rd(`UART_OFF_LCTL);
      check("depth field", q, 32'(d << 4));
    end
    wr(`UART_OFF_LCTL, 32'h0);
    wr(`UART_OFF_DIVLO, 32'h4);
    wr(`UART_OFF_DIVHI, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_parity;
    for (int p = 1; p < 3; p++)
    begin
      wr(`UART_OFF_LCTL, 32'(p));
      i_uart_line_node.par = 2'(p);
      wr(`UART_OFF_DATA, 32'(8'h3C + p));
      tx_expect(8'(8'h3C + p));
    end
    wr(`UART_OFF_ISTAT, 32'h1F);
    i_uart_line_node.send(8'h5A, 1'b1, 1'b0);
    repeat (10) @(posedge CLK);
    rd(`UART_OFF_ISTAT);
    check("parity flag", q[2], 1);
    rd(`UART_OFF_DATA);
    check("rx byte", q, 32'h5A);
    wr(`UART_OFF_ISTAT, 32'h1F);
    i_uart_line_node.send(8'hC3, 1'b0, 1'b1);
    repeat (10) @(posedge CLK);
    rd(`UART_OFF_ISTAT);
    check("frame flag", q[3], 1);
    rd(`UART_OFF_DATA);
    check("rx byte", q, 32'hC3);
    $display("test parity done");
  endtask
  task automatic t_rs485;
    int n;
    int w;
    wr(`UART_OFF_LCTL, 32'h4);
    i_uart_line_node.par = 2'h0;
    repeat (3) @(posedge CLK);
    check("idle DE", DE, 0);
    check("idle RE_N", RE_N, 0);
    wr(`UART_OFF_ISTAT, 32'h1F);
    wr(`UART_OFF_DATA, 32'hA5);
    n = 0;
    while (DE !== 1'b1 && n < 20)
    begin
      @(posedge CLK);
      n++;
    end
    w = 0;
    while (DE === 1'b1 && w < 1000)
    begin
      @(posedge CLK);
      w++;
    end
    check("driver window", 32'(w >= 119 && w <= 121), 1);
    if (n >= 20 || w >= 1000)
      test_done();
    tx_expect(8'hA5);
    rd(`UART_OFF_ISTAT);
    check("tx done", q[1], 1);
    wr(`UART_OFF_ISTAT, 32'h2);
    rd(`UART_OFF_ISTAT);
    check("tx done cleared", q[1], 0);
    $display("test rs485 done");
  endtask
  task automatic t_loop;
    int cd [7];
    int cs [7];
    int base;
    int thr;
    cd = '{0, 0, 0, 0, 1, 2, 3};
    cs = '{0, 1, 2, 3, 1, 2, 3};
    wr(`UART_OFF_IMASK, 32'h1);
    for (int c = 0; c < 7; c++)
    begin
      base = 16 << cd[c];
      thr = (cs[c] == 0) ? 1 : (cs[c] == 1) ? base / 4 : (cs[c] == 2) ? base / 2 : base - 2;
      wr(`UART_OFF_LCTL, 32'((cd[c] << 4) | 8));
      wr(`UART_OFF_FCTL, 32'(cs[c] | 12));
      wr(`UART_OFF_ISTAT, 32'h1F);
      for (int i = 0; i < thr; i++)
      begin
        wr(`UART_OFF_DATA, 32'(8'h40 + i));
        if (i == thr - 2)
        begin
          check("loop TXD", TXD, 1);
          check("loop DE", DE, 0);
          check("loop RE_N", RE_N, 1);
          wait_lvl(thr - 1);
          rd(`UART_OFF_ISTAT);
          check("below trigger", q[0], 0);
          check("irq low", IRQ, 0);
        end
      end
      wait_lvl(thr);
      rd(`UART_OFF_ISTAT);
      check("at trigger", q[0], 1);
      check("irq high", IRQ, 1);
    end
    for (int i = 0; i < 3; i++) wr(`UART_OFF_DATA, 32'h77);
    wait_lvl(128);
    rd(`UART_OFF_LSTAT);
    check("rx full", q[3], 1);
    repeat (60) @(posedge CLK);
    rd(`UART_OFF_ISTAT);
    check("overrun", q[4], 1);
    rd(`UART_OFF_DATA);
    check("looped byte", q, 32'h40);
    wr(`UART_OFF_IMASK, 32'h0);
    repeat (2) @(posedge CLK);
    check("irq masked", IRQ, 0);
    $display("test loopback done");
  endtask
  initial
  begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_parity();
    t_rs485();
    t_loop();
    test_done();
  end
endmodule
`default_nettype wire

/* verification/uart_line_node.sv */
// Purpose: Remote serial node on the far side of the line transceiver.
// Assumes: Bit time is div system clock cycles; the receive line idles high through its bias.
// Notes: send can break parity or stop on command to provoke receive errors.
`timescale 1ns/1ps
`default_nettype none
module uart_line_node (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int div = 4;
  logic [1:0] par = 2'h0;
  int perr = 0;
  logic [7:0] rb;
  logic [7:0] got_q[$];
  initial rxd = 1'b1;
  function automatic logic pbit(input logic [7:0] b);
    return (par == 2'h1) ? ~^b : ^b;
  endfunction
  task automatic send(input logic [7:0] b, input logic bad_p, input logic bad_s);
    logic [10:0] f;
    int n;
    f = (par == 2'h0) ? {1'b1, ~bad_s, b, 1'b0} : {~bad_s, pbit(b) ^ bad_p, b, 1'b0};
    n = (par == 2'h0) ? 10 : 11;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      rxd <= f[i];
      repeat (div - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
  // Samples each bit in its middle so that edge jitter of a cycle does no harm.
  initial forever
  begin
    @(negedge txd);
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (div) @(posedge clk);
      rb[i] = txd;
    end
    if (par != 2'h0)
    begin
      repeat (div) @(posedge clk);
      if (txd !== pbit(rb)) perr++;
    end
    repeat (div) @(posedge clk);
    if (txd !== 1'b1) perr++;
    got_q.push_back(rb);
  end
endmodule
`default_nettype wire
